// ===== hw/bess_setting_store.sv
// Purpose: holds the loaded defaults and the user written settings
// Assumes: load and write never both in one cycle (load only in init)
// Notes:   read data comes out of a register; only reset and the default load clear it
`timescale 1ns/1ns
module bess_setting_store
  import bess_pkg::*;
(
  // clock and reset
  input  wire logic       sys_clk,
  input  wire logic       reset,
  // default load from nonvolatile storage and straps
  input  wire logic       load_stb,
  input  wire logic [7:0] load_vset,
  // user write port
  input  wire logic       wr_stb,
  input  wire logic [7:0] wr_vset,
  input  wire logic [1:0] wr_range,
  input  wire logic [1:0] wr_ramp,
  input  wire logic [1:0] wr_ss,
  input  wire logic       wr_continuous_switching_mode,
  input  wire logic       wr_single,
  // registered read data
  output logic [7:0]      rd_vset,
  output logic [1:0]      rd_range,
  output logic [1:0]      rd_ramp,
  output logic [1:0]      rd_ss,
  output logic            rd_continuous_switching_mode,
  output logic            rd_single
);
  // ==========================================================
  // storage: enable toggles never reach this reset, only supply loss
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      rd_vset   <= VSET_RST;
      rd_range  <= VRANGE_RST;
      rd_ramp   <= VRAMP_RST;
      rd_ss     <= SS_DUR_RST;
      rd_continuous_switching_mode   <= 1'b0;
      rd_single <= 1'b0;
    end else if (load_stb) begin
      // defaults: voltage from strap, rest from reset values
      rd_vset   <= load_vset;
      rd_range  <= VRANGE_RST;
      rd_ramp   <= VRAMP_RST;
      rd_ss     <= SS_DUR_RST;
      rd_continuous_switching_mode   <= 1'b0;
      rd_single <= 1'b0;
    end else if (wr_stb) begin
      rd_vset   <= wr_vset;
      rd_range  <= wr_range;
      rd_ramp   <= wr_ramp;
      rd_ss     <= wr_ss;
      rd_continuous_switching_mode   <= wr_continuous_switching_mode;
      rd_single <= wr_single;
    end
  end
endmodule

// ===== hw/bess_top.sv
// Purpose: enable-line sequencer, start-up ramp and mode select for a buck
// Assumes: reset is the supply undervoltage lockout, held until supply is good
// Notes:   analog loops, thresholds and strap decoding stay outside
//
// How it works
// - mode bit 0 saves power, 1 forces PWM
// - forced mode continuous constant-frequency switching once the start-up ramp is done
// - saving mode picks CCM, DCM or PFM by load
// - PFM pulses only on internal clock grid
// - hold enable low until defaults and straps loaded
// - faults also pull enable low
// - shared enable line gates every stacked converter
// - standalone bit stops faults pulling enable low
// - release enable; high runs, low shuts down
// - serial interface enabled right after initialization
// - enable toggling keeps loaded register values
// - init order: pull low, reference, straps, load
// - registers usable while idle; ramp after delay
// - soft-start field selects 0.5, 1, 2, 4 ms
// - mid-ramp setpoint, range, duration writes deferred
// - ramp to start code, then to new code
// - ramp starts from existing output level
// - start-up ramp always uses discontinuous conduction
// - settings written while disabled apply next enable
`timescale 1ns/1ns
module bess_top
  import bess_pkg::*;
(
  // clock and reset (reset = undervoltage lockout)
  input  wire logic       sys_clk,
  input  wire logic       reset,
  // enable pin, open drain
  input  wire logic       en_pin_i,
  output logic            en_pin_o,
  output logic            en_pin_oe,
  // fault inputs from the analog side
  input  wire logic       thermal_fault,
  input  wire logic       overvoltage_fault,
  // strap sampling and mode pin
  input  wire logic [7:0] voltage_strap_code,
  input  wire logic       mode_pin_force,
  // load level hints from the current sense
  input  wire logic       load_low,
  input  wire logic       load_very_low,
  // existing output level, as a setpoint code
  input  wire logic [7:0] prebias_code,
  // register write port from the serial interface
  input  wire logic       cfg_wr,
  input  wire logic [7:0] cfg_voltage_setpoint_code,
  input  wire logic [1:0] cfg_voltage_span_select,
  input  wire logic [1:0] cfg_slew_rate_select,
  input  wire logic [1:0] cfg_soft_start_duration,
  input  wire logic       cfg_forced_pulse_enable_bit,
  input  wire logic       cfg_standalone_bit,
  // register read back
  output logic [7:0]      rd_voltage_setpoint_code,
  output logic [1:0]      rd_voltage_span_select,
  output logic [1:0]      rd_slew_rate_select,
  output logic [1:0]      rd_soft_start_duration,
  output logic            rd_forced_pulse_enable_bit,
  output logic            rd_standalone_bit,
  // status and power-stage control
  output logic            serial_enable_q,
  output logic            converter_on_q,
  output logic            soft_start_active_q,
  output logic [1:0]      conduction_mode_q,
  output logic            switch_pulse_q,
  output logic [7:0]      target_level_field_q,
  output logic [1:0]      active_span_q,
  output logic [7:0]      ramp_level_q
);
  // ==========================================================
  // declarations
  bess_state_t state_q;                 // sequencer state
  logic [16:0] cnt_q;                   // step / ramp timer
  logic [2:0]  en_sync_q;               // enable pin synchroniser
  logic        en_level_q;              // debounced enable level
  logic [2:0]  mode_sync_q;             // mode pin synchroniser
  logic        mode_force_q;            // debounced mode pin
  logic [7:0]  strap_q;                 // captured strap code
  logic        load_stb;                // default load strobe
  logic [7:0]  ss_code_q;               // code latched at ramp start
  logic [1:0]  ss_dur_q;                // duration latched at ramp start
  logic [16:0] ss_len;                  // ramp length in cycles
  logic [2:0]  sw_cnt_q;                // switching clock grid
  logic [10:0] dvs_q;                   // slew step timer
  // ramp length per duration code
  function automatic logic [16:0] ss_cycles(input logic [1:0] d);
    unique case (d)
      2'h0: ss_cycles = 17'(SS_C0);
      2'h1: ss_cycles = 17'(SS_C1);
      2'h2: ss_cycles = 17'(SS_C2);
      2'h3: ss_cycles = 17'(SS_C3);
    endcase
  endfunction
  // slew step length per rate code
  function automatic logic [10:0] step_cycles(input logic [1:0] r);
    unique case (r)
      2'h0: step_cycles = 11'(STEP_DUS0 * CYC_PER_DUS);
      2'h1: step_cycles = 11'(STEP_DUS1 * CYC_PER_DUS);
      2'h2: step_cycles = 11'(STEP_DUS2 * CYC_PER_DUS);
      2'h3: step_cycles = 11'(STEP_DUS3 * CYC_PER_DUS);
    endcase
  endfunction
  assign ss_len = ss_cycles(ss_dur_q);
  // ==========================================================
  // settings store; supply reset only, enable never clears it
  bess_setting_store u_store (
    .sys_clk   (sys_clk),
    .reset     (reset),
    .load_stb  (load_stb),
    .load_vset (strap_q),
    .wr_stb    (cfg_wr & serial_enable_q),
    .wr_vset   (cfg_voltage_setpoint_code),
    .wr_range  (cfg_voltage_span_select),
    .wr_ramp   (cfg_slew_rate_select),
    .wr_ss     (cfg_soft_start_duration),
    .wr_continuous_switching_mode   (cfg_forced_pulse_enable_bit),
    .wr_single (cfg_standalone_bit),
    .rd_vset   (rd_voltage_setpoint_code),
    .rd_range  (rd_voltage_span_select),
    .rd_ramp   (rd_slew_rate_select),
    .rd_ss     (rd_soft_start_duration),
    .rd_continuous_switching_mode   (rd_forced_pulse_enable_bit),
    .rd_single (rd_standalone_bit)
  );
  // ==========================================================
  // pin synchronisers: change counts once stages 2 and 3 agree
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      en_sync_q    <= 3'h0;
      en_level_q   <= 1'b0;
      mode_sync_q  <= 3'h0;
      mode_force_q <= 1'b0;
    end else begin
      en_sync_q   <= {en_sync_q[1:0], en_pin_i};
      mode_sync_q <= {mode_sync_q[1:0], mode_pin_force};
      if (en_sync_q[1] == en_sync_q[2]) begin
        en_level_q <= en_sync_q[2];
      end
      if (mode_sync_q[1] == mode_sync_q[2]) begin
        mode_force_q <= mode_sync_q[2];
      end
    end
  end
  // ==========================================================
  // sequencer: init steps, then enable-driven ramp
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      state_q <= BESS_ST_PULLDN;
      cnt_q   <= 17'h0_0000;
    end else begin
      unique case (state_q)
        BESS_ST_PULLDN: begin
          state_q <= BESS_ST_REF;
          cnt_q   <= 17'(REF_SETTLE_C);
        end
        BESS_ST_REF, BESS_ST_STRAP, BESS_ST_LOAD: begin
          // each init step counts down, then hands over to the next
          if (cnt_q != 17'h0_0000) begin
            cnt_q <= cnt_q - 17'h0_0001;
          end else if (state_q == BESS_ST_REF) begin
            state_q <= BESS_ST_STRAP;
            cnt_q   <= 17'(STRAP_C);
          end else if (state_q == BESS_ST_STRAP) begin
            state_q <= BESS_ST_LOAD;
            cnt_q   <= 17'(NVM_LOAD_C);
          end else begin
            state_q <= BESS_ST_IDLE;
          end
        end
        BESS_ST_IDLE: begin
          // the line level is the wired result of every stacked part
          if (en_level_q) begin
            state_q <= BESS_ST_DELAY;
            cnt_q   <= 17'(START_DLY_C);
          end
        end
        BESS_ST_DELAY: begin
          if (!en_level_q) begin
            state_q <= BESS_ST_IDLE;
          end else if (cnt_q == 17'h0_0000) begin
            state_q <= BESS_ST_SOFT;
          end else begin
            cnt_q <= cnt_q - 17'h0_0001;
          end
        end
        BESS_ST_SOFT: begin
          if (!en_level_q) begin
            state_q <= BESS_ST_IDLE;
          end else if (cnt_q >= ss_len - 17'h0_0001) begin
            state_q <= BESS_ST_RUN;
          end else begin
            cnt_q <= cnt_q + 17'h0_0001;
          end
        end
        BESS_ST_RUN: begin
          if (!en_level_q) begin
            state_q <= BESS_ST_IDLE;
          end
        end
      endcase
    end
  end
  assign load_stb = (state_q == BESS_ST_LOAD) && (cnt_q == 17'h0_0000);
  // ==========================================================
  // strap capture during the strap step
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      strap_q <= 8'h00;
    end else if (state_q == BESS_ST_STRAP) begin
      strap_q <= voltage_strap_code;
    end
  end
  // ==========================================================
  // open-drain enable: low in init always, on fault unless standalone
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      en_pin_oe <= 1'b1;
      en_pin_o  <= 1'b0;
    end else begin
      en_pin_o  <= 1'b0;
      if (state_q < BESS_ST_IDLE || load_stb) begin
        en_pin_oe <= 1'b1;
      end else begin
        en_pin_oe <= (thermal_fault | overvoltage_fault) & ~rd_standalone_bit;
      end
    end
  end
  // ==========================================================
  // serial interface comes up once init is done, nothing else gates it
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      serial_enable_q <= 1'b0;
    end else if (load_stb) begin
      serial_enable_q <= 1'b1;
    end
  end
  // ==========================================================
  // start-of-ramp capture: settings frozen while ramping
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      ss_code_q     <= VSET_RST;
      ss_dur_q      <= SS_DUR_RST;
      active_span_q <= VRANGE_RST;
    end else if (state_q == BESS_ST_IDLE || state_q == BESS_ST_DELAY) begin
      // writes while disabled are taken at the next enable
      ss_code_q     <= rd_voltage_setpoint_code;
      ss_dur_q      <= rd_soft_start_duration;
      active_span_q <= rd_voltage_span_select;
    end else if (state_q == BESS_ST_RUN) begin
      active_span_q <= rd_voltage_span_select;
    end
  end
  // ==========================================================
  // ramp level: soft start from prebias, then slew to new setpoint
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      ramp_level_q         <= 8'h00;
      target_level_field_q <= VSET_RST;
      dvs_q                <= 11'h000;
    end else begin
      unique case (state_q)
        BESS_ST_DELAY: begin
          ramp_level_q         <= prebias_code;
          target_level_field_q <= ss_code_q;
        end
        BESS_ST_SOFT: begin
          // linear ramp; below the prebias level nothing is driven out
          if (ramp_level_q < ss_code_q &&
              cnt_q >= 17'((32'(ramp_level_q) * 32'(ss_len)) / 32'(ss_code_q))) begin
            ramp_level_q <= ramp_level_q + 8'h01;
          end
          target_level_field_q <= ss_code_q;
        end
        BESS_ST_RUN: begin
          target_level_field_q <= rd_voltage_setpoint_code;
          if (dvs_q != 11'h000) begin
            dvs_q <= dvs_q - 11'h001;
          end else if (ramp_level_q != rd_voltage_setpoint_code) begin
            dvs_q        <= step_cycles(rd_slew_rate_select);
            ramp_level_q <= (ramp_level_q < rd_voltage_setpoint_code) ? ramp_level_q + 8'h01
                                                                      : ramp_level_q - 8'h01;
          end
        end
        default: begin
          ramp_level_q <= 8'h00;
          dvs_q        <= 11'h000;
        end
      endcase
    end
  end
  // ==========================================================
  // conduction mode and power-stage status
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      conduction_mode_q   <= BESS_COND_OFF;
      converter_on_q      <= 1'b0;
      soft_start_active_q <= 1'b0;
    end else begin
      converter_on_q      <= (state_q == BESS_ST_SOFT) || (state_q == BESS_ST_RUN);
      soft_start_active_q <= (state_q == BESS_ST_SOFT);
      if (state_q == BESS_ST_SOFT) begin
        conduction_mode_q <= BESS_COND_DCM;
      end else if (state_q != BESS_ST_RUN) begin
        conduction_mode_q <= BESS_COND_OFF;
      end else if (rd_forced_pulse_enable_bit || mode_force_q) begin
        conduction_mode_q <= BESS_COND_CCM;
      end else if (load_very_low) begin
        conduction_mode_q <= BESS_COND_PFM;
      end else if (load_low) begin
        conduction_mode_q <= BESS_COND_DCM;
      end else begin
        conduction_mode_q <= BESS_COND_CCM;
      end
    end
  end
  // ==========================================================
  // switching pulses: every pulse sits on the internal clock grid
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      sw_cnt_q       <= 3'h0;
      switch_pulse_q <= 1'b0;
    end else begin
      sw_cnt_q <= (sw_cnt_q == 3'(SW_PERIOD_C - 1)) ? 3'h0 : sw_cnt_q + 3'h1;
      if (sw_cnt_q != 3'h0 || !converter_on_q) begin
        switch_pulse_q <= 1'b0;
      end else if (conduction_mode_q == BESS_COND_PFM) begin
        switch_pulse_q <= ramp_level_q < target_level_field_q;
      end else begin
        switch_pulse_q <= 1'b1;
      end
    end
  end
endmodule

// ===== pkg/bess_pkg.sv
// Purpose: shared constants for the buck enable / start-up sequencer
// Assumes: sys_clk at 20 MHz
// Notes:   times are kept in their own unit, cycle counts derive from them; init steps and switch period are set in cycles
package bess_pkg;
  // ==========================================================
  // clock
  localparam int unsigned CLK_HZ        = 20_000_000;
  localparam int unsigned CLK_KHZ       = CLK_HZ / 1000;
  // ==========================================================
  // soft-start durations in microseconds
  localparam int unsigned SS_T0_US      = 500;
  localparam int unsigned SS_T1_US      = 1000;
  localparam int unsigned SS_T2_US      = 2000;
  localparam int unsigned SS_T3_US      = 4000;
  localparam int unsigned SS_C0         = SS_T0_US * (CLK_HZ / 1_000_000);
  localparam int unsigned SS_C1         = SS_T1_US * (CLK_HZ / 1_000_000);
  localparam int unsigned SS_C2         = SS_T2_US * (CLK_HZ / 1_000_000);
  localparam int unsigned SS_C3         = SS_T3_US * (CLK_HZ / 1_000_000);
  localparam logic [1:0]  SS_DUR_RST    = 2'h1;
  // ==========================================================
  // start delay after enable, microseconds
  localparam int unsigned START_DLY_US  = 10;
  localparam int unsigned START_DLY_C   = START_DLY_US * (CLK_HZ / 1_000_000);
  // ==========================================================
  // initialization step lengths (cycles)
  localparam int unsigned REF_SETTLE_C  = 16;
  localparam int unsigned STRAP_C       = 8;
  localparam int unsigned NVM_LOAD_C    = 8;
  // ==========================================================
  // register reset values
  localparam logic [7:0]  VSET_RST      = 8'h00;
  localparam logic [1:0]  VRANGE_RST    = 2'h2;
  localparam logic [1:0]  VRAMP_RST     = 2'h0;
  // ==========================================================
  // slew step times in tenths of a microsecond
  localparam int unsigned STEP_DUS0     = 5;
  localparam int unsigned STEP_DUS1     = 10;
  localparam int unsigned STEP_DUS2     = 50;
  localparam int unsigned STEP_DUS3     = 100;
  localparam int unsigned CYC_PER_DUS   = CLK_HZ / 10_000_000;
  // ==========================================================
  // switching pulse grid (cycles of sys_clk per switching period)
  localparam int unsigned SW_PERIOD_C   = 8;
  // ==========================================================
  // conduction modes presented to the power stage
  typedef enum logic [1:0] {
    BESS_COND_OFF = 2'b00,
    BESS_COND_CCM = 2'b01,
    BESS_COND_DCM = 2'b10,
    BESS_COND_PFM = 2'b11
  } bess_cond_t;
  // sequencer states
  typedef enum logic [2:0] {
    BESS_ST_PULLDN  = 3'b000,
    BESS_ST_REF     = 3'b001,
    BESS_ST_STRAP   = 3'b010,
    BESS_ST_LOAD    = 3'b011,
    BESS_ST_IDLE    = 3'b100,
    BESS_ST_DELAY   = 3'b101,
    BESS_ST_SOFT    = 3'b110,
    BESS_ST_RUN     = 3'b111
  } bess_state_t;
endpackage

// ===== testbench/bess_enable_partner.sv
// Purpose: host enable driver plus one more stacked converter
// Assumes: line has a pull-up, host drives through a resistor
// Notes:   the other converter is still initializing for STACK_INIT_C cycles
`timescale 1ns/1ns
module bess_enable_partner #(
  parameter int STACK_INIT_C = 1500 // init length of the other part
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic host_en,
  input wire logic stack_fault,
  input wire logic en_pin_o,
  input wire logic en_pin_oe,
  output logic     line
);
  int init_q; // cycles since lockout ended
  // other part holds the shared line low while it loads or faults
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) init_q <= 0;
    else if (init_q < STACK_INIT_C) init_q <= init_q + 1;
  end
  // wired-and of every party on the one line
  assign line = host_en && !stack_fault && init_q >= STACK_INIT_C && !(en_pin_oe && !en_pin_o);
endmodule

// ===== testbench/bess_monitor.sv
// Purpose: port checker for the start-up sequencer
// Assumes: one clock domain, reset is supply lockout
// Notes:   bound to every bess_top below
`timescale 1ns/1ns
module bess_monitor
  import bess_pkg::*;
(
  // clock and reset
  input wire logic       sys_clk,
  input wire logic       reset,
  // enable line and faults
  input wire logic       en_pin_oe,
  input wire logic       thermal_fault,
  input wire logic       overvoltage_fault,
  // settings, status and enable line level
  input wire logic       rd_forced_pulse_enable_bit,
  input wire logic       rd_standalone_bit,
  input wire logic       serial_enable_q,
  input wire logic       converter_on_q,
  input wire logic       soft_start_active_q,
  input wire logic [1:0] conduction_mode_q,
  input wire logic       switch_pulse_q,
  input wire logic [7:0] target_level_field_q,
  input wire logic       en_pin_i
);
  // ==========================================
  // all checks share the one clock and reset
  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);
  a_init_hold: assert property (!serial_enable_q |-> en_pin_oe)
    else $error("enable line let go before init done");
  a_init_release: assert property ($rose(serial_enable_q) && !thermal_fault && !overvoltage_fault
    |=> !en_pin_oe)
    else $error("enable line held after init");
  a_serial_stays: assert property (serial_enable_q |=> serial_enable_q)
    else $error("serial interface dropped");
  a_fault_pull: assert property ((thermal_fault || overvoltage_fault) && !rd_standalone_bit
    |-> ##[0:2] en_pin_oe)
    else $error("fault did not pull enable line");
  a_alone_free: assert property (rd_standalone_bit [*3] ##0 serial_enable_q |-> !en_pin_oe)
    else $error("standalone part pulled enable line");
  a_soft_dcm: assert property (soft_start_active_q [*2] |-> conduction_mode_q == BESS_COND_DCM)
    else $error("ramp not in discontinuous mode");
  a_soft_hold: assert property (soft_start_active_q [*3] |-> $stable(target_level_field_q))
    else $error("target moved during ramp");
  a_forced_ccm: assert property ((converter_on_q && !soft_start_active_q && rd_forced_pulse_enable_bit) [*3]
    |-> conduction_mode_q == BESS_COND_CCM)
    else $error("forced mode not continuous");
  a_pulse_grid: assert property (switch_pulse_q |=> !switch_pulse_q [*7])
    else $error("switch pulse off the clock grid");
  a_low_off: assert property (!en_pin_i [*8] |-> !converter_on_q)
    else $error("converter on with enable line low");
endmodule
bind bess_top bess_monitor u_bess_monitor (.sys_clk(sys_clk), .reset(reset), .en_pin_oe(en_pin_oe),
  .thermal_fault(thermal_fault), .overvoltage_fault(overvoltage_fault), .en_pin_i(en_pin_i),
  .rd_forced_pulse_enable_bit(rd_forced_pulse_enable_bit), .rd_standalone_bit(rd_standalone_bit),
  .serial_enable_q(serial_enable_q), .converter_on_q(converter_on_q), .switch_pulse_q(switch_pulse_q),
  .soft_start_active_q(soft_start_active_q), .conduction_mode_q(conduction_mode_q),
  .target_level_field_q(target_level_field_q));

// ===== testbench/tb_bess_top.sv
// Purpose: sequence tests for the start-up sequencer
// Assumes: 20 MHz clock, strap code and prebias fixed
// Notes:   short soft start chosen so the run stays brief
`timescale 1ns/1ns
module tb_bess_top import bess_pkg::*; ;
  logic sys_clk = 0, reset = 1, host_en = 0, stack_fault = 0, thermal_fault = 0, overvoltage_fault = 0;
  logic mode_pin_force = 0, load_low = 0, load_very_low = 0, cfg_wr = 0, cfg_forced_pulse_enable_bit = 0;
  logic cfg_standalone_bit = 0, en_pin_i, en_pin_o, en_pin_oe, rd_forced_pulse_enable_bit, rd_standalone_bit;
  logic [7:0] voltage_strap_code = 8'h3c, prebias_code = 8'h08, cfg_voltage_setpoint_code = 8'h00;
  logic [1:0] cfg_voltage_span_select = 2'h2, cfg_slew_rate_select = 2'h0, cfg_soft_start_duration = 2'h1;
  logic [7:0] rd_voltage_setpoint_code, target_level_field_q, ramp_level_q;
  logic [1:0] rd_voltage_span_select, rd_slew_rate_select, rd_soft_start_duration, conduction_mode_q, active_span_q;
  logic serial_enable_q, converter_on_q, soft_start_active_q, switch_pulse_q;
  int err_count = 0, samples_checked = 0, cycles_run = 0, pulses = 0;
  bess_cond_t exp_m [3] = '{BESS_COND_CCM, BESS_COND_DCM, BESS_COND_PFM};
  always #25 sys_clk = ~sys_clk;
  bess_top u_bess_top (.*);
  bess_enable_partner u_bess_enable_partner (.sys_clk, .reset, .host_en, .stack_fault, .en_pin_o,
    .en_pin_oe, .line(en_pin_i));
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
    @(negedge sys_clk);
  endtask
  // one write of all fields, then wait for read back
  task automatic wr(input logic [7:0] v, input logic [1:0] ss, input logic fp, input logic sg);
    @(posedge sys_clk);
    cfg_wr <= 1'b1;
    cfg_voltage_setpoint_code <= v;
    cfg_soft_start_duration <= ss;
    cfg_forced_pulse_enable_bit <= fp;
    cfg_standalone_bit <= sg;
    @(posedge sys_clk);
    cfg_wr <= 1'b0;
    cyc(3);
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // cut a hang short
  always @(posedge sys_clk) begin
    cycles_run <= cycles_run + 1;
    if (cycles_run == 30000) begin
      err_count++;
      complete_run();
    end
  end
  initial begin
    cyc(7);
    chk("oe_rst", en_pin_oe, 1);
    @(posedge sys_clk);
    reset <= 1'b0;
    cyc(3);
    chk("ser_early", serial_enable_q, 0);
    cyc(40);
    chk("ser_on", serial_enable_q, 1);
    chk("oe_rel", en_pin_oe, 0);
    chk("od_low", 8'(en_pin_o), 8'h00);
    chk("vset_def", rd_voltage_setpoint_code, 8'h3c);
    chk("span_def", rd_voltage_span_select, 2);
    chk("ss_def", rd_soft_start_duration, 1);
    chk("slew_def", 8'(rd_slew_rate_select), 8'h00);
    wr(8'h10, 2'h0, 0, 0);
    chk("vset_wr", rd_voltage_setpoint_code, 8'h10);
    chk("ss_wr", rd_soft_start_duration, 0);
    for (int k = 0; k < 2; k++) begin
      thermal_fault <= k == 0;
      overvoltage_fault <= k == 1;
      cyc(3);
      chk("oe_fault", en_pin_oe, 1);
      thermal_fault <= 0;
      overvoltage_fault <= 0;
      cyc(3);
      chk("oe_clear", en_pin_oe, 0);
    end
    wr(8'h10, 2'h0, 0, 1);
    thermal_fault <= 1;
    cyc(3);
    chk("oe_alone", en_pin_oe, 0);
    thermal_fault <= 0;
    wr(8'h10, 2'h0, 0, 0);
    host_en <= 1;
    cyc(300);
    chk("stack_hold", converter_on_q, 0);
    for (int i = 0; i < 1500 && converter_on_q !== 1; i++) cyc(0);
    chk("conv_on", converter_on_q, 1);
    chk("soft_dcm", 8'(conduction_mode_q), 8'(BESS_COND_DCM));
    chk("prebias", 8'(ramp_level_q >= 8'h08), 1);
    cfg_voltage_span_select <= 2'h1;
    wr(8'h20, 2'h3, 1, 0);
    chk("tgt_hold", target_level_field_q, 8'h10);
    chk("span_hold", 8'(active_span_q), 8'h02);
    for (int i = 0; i < 11000 && soft_start_active_q !== 0; i++) cyc(0);
    chk("soft_end", soft_start_active_q, 0);
    cyc(400);
    chk("tgt_new", target_level_field_q, 8'h20);
    chk("span_new", 8'(active_span_q), 8'h01);
    chk("ramp_new", ramp_level_q, 8'h20);
    chk("forced", 8'(conduction_mode_q), 8'(BESS_COND_CCM));
    // one pulse per switching period in continuous mode
    repeat (16) begin
      cyc(0);
      pulses += switch_pulse_q;
    end
    chk("pulses", 8'(pulses), 8'h02);
    wr(8'h20, 2'h3, 0, 0);
    for (int k = 0; k < 3; k++) begin
      load_low <= k > 0;
      load_very_low <= k == 2;
      cyc(6);
      chk("save_mode", 8'(conduction_mode_q), 8'(exp_m[k]));
    end
    mode_pin_force <= 1;
    cyc(8);
    chk("pin_mode", 8'(conduction_mode_q), 8'(BESS_COND_CCM));
    stack_fault <= 1;
    cyc(12);
    chk("stack_off", converter_on_q, 0);
    chk("off_mode", 8'(conduction_mode_q), 8'(BESS_COND_OFF));
    chk("keep_vset", rd_voltage_setpoint_code, 8'h20);
    complete_run();
  end
endmodule
